/* pkg/isr_map.vh */
// Register map and field positions of the start-reservation controller.
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
`define ISR_OFS_CTRL0 12'h000
`define ISR_OFS_STAT 12'h004
`define ISR_OFS_FLAG 12'h008
`define ISR_OFS_WIDTH 12'h00C
`define ISR_OFS_SHIFT 12'h010
`define ISR_C0_ENABLE 7
`define ISR_C0_RELEASE 6
`define ISR_C0_SPIE 4
`define ISR_C0_START 1
`define ISR_C0_STOP 0
`define ISR_ST_MASTER 7
`define ISR_ST_ARBLOSS 6
`define ISR_ST_ACK 2
`define ISR_ST_STD 1
`define ISR_ST_SPD 0
`define ISR_FL_START_FAILURE_FLAG 7
`define ISR_FL_BUSY 6
`define ISR_FL_START_WITHOUT_STOP_ENABLE 1
`define ISR_FL_RSVDIS 0
`define ISR_WL_LSB 0
`define ISR_WH_LSB 8
`define ISR_WIDTH_RST 8'h10
`define ISR_LAST_BIT 4'h8
`endif

/* rtl/isr_line_sync.v */
// Two-flop synchronisers for the bus lines with start and stop detection.
`timescale 1ns/1ps
module isr_line_sync (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Raw bus lines
  input wire scl_in,
  input wire sda_in,
  // Synchronised levels and conditions
  output reg scl_s,
  output reg sda_s,
  output wire start_cond,
  output wire stop_cond
);
  reg scl_m;
  reg sda_m;
  reg sda_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m <= 1'b1;
      sda_m <= 1'b1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      sda_m <= sda_in;
      scl_s <= scl_m;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // Data may only change while the clock is high for a start or stop.
  assign start_cond = scl_s && sda_d && !sda_s;
  assign stop_cond = scl_s && !sda_d && sda_s;
endmodule

/* rtl/isr_start_ctrl.v */
// Start request, communication reservation and master byte engine with APB registers.
`timescale 1ns/1ps
`include "isr_map.vh"
module isr_start_ctrl #(
  parameter WW = 8
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Bus lines, open drain
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // Event to the interrupt controller
  output reg bus_interrupt
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_WAIT = 3'd2;
  localparam S_BITLO = 3'd3;
  localparam S_BITHI = 3'd4;
  localparam S_STOP = 3'd5;

  wire scl_s;
  wire sda_s;
  wire start_cond;
  wire stop_cond;

  isr_line_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .start_cond(start_cond),
    .stop_cond(stop_cond)
  );

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  reg enable_r, release_r, spie_r, start_req_r, stop_req_r;
  reg start_without_stop_enable_r, rsvdis_r, start_failure_flag_r, busy_r;
  reg master_r, arbloss_r, ack_r, std_r, spd_r;
  reg reserve_r;
  reg [WW-1:0] wl_r;
  reg [WW-1:0] wh_r;
  reg [7:0] shift_r;
  reg [2:0] state_r;
  reg [WW:0] cnt_r;
  reg [3:0] bit_r;
  reg [1:0] ph_r;
  reg enable_d;

  function sel;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  wire wr = psel && penable && pwrite && pready;
  wire wr_c0 = wr && sel(paddr, `ISR_OFS_CTRL0);
  wire wr_fl = wr && sel(paddr, `ISR_OFS_FLAG);
  wire wr_wd = wr && sel(paddr, `ISR_OFS_WIDTH);
  wire wr_sh = wr && sel(paddr, `ISR_OFS_SHIFT);
  wire mapped = sel(paddr, `ISR_OFS_CTRL0) || sel(paddr, `ISR_OFS_STAT) ||
                sel(paddr, `ISR_OFS_FLAG) || sel(paddr, `ISR_OFS_WIDTH) ||
                sel(paddr, `ISR_OFS_SHIFT);
  wire en_rise = enable_r && !enable_d;
  wire cnt_done = (cnt_r == {(WW+1){1'b0}});
  wire [WW:0] lo_ld = {1'b0, wl_r};
  wire [WW:0] hi_ld = {1'b0, wh_r};

  // --------------------------------------------------------------
  // APB slave: one wait-free access phase
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        if (sel(paddr, `ISR_OFS_CTRL0)) begin
          prdata[`ISR_C0_ENABLE] <= enable_r;
          prdata[`ISR_C0_RELEASE] <= release_r;
          prdata[`ISR_C0_SPIE] <= spie_r;
          prdata[`ISR_C0_START] <= start_req_r;
          prdata[`ISR_C0_STOP] <= stop_req_r;
        end else if (sel(paddr, `ISR_OFS_STAT)) begin
          prdata[`ISR_ST_MASTER] <= master_r;
          prdata[`ISR_ST_ARBLOSS] <= arbloss_r;
          prdata[`ISR_ST_ACK] <= ack_r;
          prdata[`ISR_ST_STD] <= std_r;
          prdata[`ISR_ST_SPD] <= spd_r;
        end else if (sel(paddr, `ISR_OFS_FLAG)) begin
          prdata[`ISR_FL_START_FAILURE_FLAG] <= start_failure_flag_r;
          prdata[`ISR_FL_BUSY] <= busy_r;
          prdata[`ISR_FL_START_WITHOUT_STOP_ENABLE] <= start_without_stop_enable_r;
          prdata[`ISR_FL_RSVDIS] <= rsvdis_r;
        end else if (sel(paddr, `ISR_OFS_WIDTH)) begin
          prdata[`ISR_WL_LSB +: WW] <= wl_r;
          prdata[`ISR_WH_LSB +: WW] <= wh_r;
        end else if (sel(paddr, `ISR_OFS_SHIFT)) begin
          prdata[7:0] <= shift_r;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= 1'b0;
      spie_r <= 1'b0;
      start_without_stop_enable_r <= 1'b0;
      rsvdis_r <= 1'b0;
      wl_r <= `ISR_WIDTH_RST;
      wh_r <= `ISR_WIDTH_RST;
      enable_d <= 1'b0;
    end else begin
      enable_d <= enable_r;
      if (wr_c0) begin
        enable_r <= pwdata[`ISR_C0_ENABLE];
        spie_r <= pwdata[`ISR_C0_SPIE];
      end
      if (wr_fl) begin
        start_without_stop_enable_r <= pwdata[`ISR_FL_START_WITHOUT_STOP_ENABLE];
        rsvdis_r <= pwdata[`ISR_FL_RSVDIS];
      end
      if (wr_wd) begin
        wl_r <= pwdata[`ISR_WL_LSB +: WW];
        wh_r <= pwdata[`ISR_WH_LSB +: WW];
      end
    end
  end

  // --------------------------------------------------------------
  // Bus state, reservation and master engine
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      start_failure_flag_r <= 1'b0;
      busy_r <= 1'b0;
      master_r <= 1'b0;
      arbloss_r <= 1'b0;
      ack_r <= 1'b0;
      std_r <= 1'b0;
      spd_r <= 1'b0;
      reserve_r <= 1'b0;
      shift_r <= 8'h00;
      state_r <= S_IDLE;
      cnt_r <= {(WW+1){1'b0}};
      bit_r <= 4'h0;
      ph_r <= 2'b00;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      bus_interrupt <= 1'b0;
    end else if (!enable_r) begin
      // A disabled controller lets go of both lines and forgets all requests.
      release_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
      reserve_r <= 1'b0;
      master_r <= 1'b0;
      std_r <= 1'b0;
      spd_r <= 1'b0;
      busy_r <= 1'b0;
      state_r <= S_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      bus_interrupt <= 1'b0;
      if (wr_sh)
        shift_r <= pwdata[7:0];
    end else begin
      bus_interrupt <= 1'b0;
      if (!cnt_done)
        cnt_r <= cnt_r - {{WW{1'b0}}, 1'b1};
      if (wr_c0) begin
        if (pwdata[`ISR_C0_START])
          start_req_r <= 1'b1;
        if (pwdata[`ISR_C0_STOP])
          stop_req_r <= 1'b1;
        if (pwdata[`ISR_C0_RELEASE])
          release_r <= 1'b1;
      end

      // Bus-level conditions seen on the lines.
      if (en_rise) begin
        busy_r <= !start_without_stop_enable_r;
        if (!sda_s && scl_s) begin
          std_r <= 1'b1;
          busy_r <= 1'b1;
        end
      end else if (start_cond) begin
        std_r <= 1'b1;
        spd_r <= 1'b0;
        busy_r <= 1'b1;
      end else if (stop_cond) begin
        spd_r <= 1'b1;
        std_r <= 1'b0;
        busy_r <= 1'b0;
        if (spie_r)
          bus_interrupt <= 1'b1;
      end

      // A release request has no other effect; the bit clears itself on the next clock.
      if (release_r) begin
        release_r <= 1'b0;
      end

      // Start request decision, taken one clock after the write.
      if (start_req_r && state_r == S_IDLE && !reserve_r) begin
        start_req_r <= 1'b0;
        if (!busy_r) begin
          state_r <= S_START;
          cnt_r <= hi_ld;
          sda_oe <= 1'b1;
          sda_out <= 1'b0;
          master_r <= 1'b1;
          start_failure_flag_r <= 1'b0;
        end else if (rsvdis_r) begin
          start_failure_flag_r <= 1'b1;
        end else if (std_r && !spd_r) begin
          reserve_r <= 1'b1;
          start_failure_flag_r <= 1'b0;
        end else begin
          start_failure_flag_r <= 1'b1;
        end
      end else if (start_req_r && state_r != S_IDLE) begin
        start_req_r <= 1'b0;
      end

      // A pending reservation drives nothing until the stop is seen.
      if (reserve_r && stop_cond && state_r == S_IDLE) begin
        reserve_r <= 1'b0;
        state_r <= S_START;
        cnt_r <= hi_ld;
        sda_oe <= 1'b1;
        sda_out <= 1'b0;
        master_r <= 1'b1;
      end

      // Address or data written while a reservation waits is discarded.
      if (wr_sh && !reserve_r) begin
        shift_r <= pwdata[7:0];
        if (state_r == S_WAIT && master_r) begin
          state_r <= S_BITLO;
          bit_r <= 4'h0;
          cnt_r <= lo_ld;
        end
      end

      case (state_r)
        S_IDLE: begin
          if (stop_req_r && !reserve_r) begin
            stop_req_r <= 1'b0;
            state_r <= S_STOP;
            ph_r <= 2'b00;
            cnt_r <= lo_ld;
            scl_oe <= 1'b1;
            scl_out <= 1'b0;
            sda_oe <= 1'b1;
            sda_out <= 1'b0;
          end
        end
        S_START: begin
          if (cnt_done) begin
            state_r <= S_WAIT;
            scl_oe <= 1'b1;
            scl_out <= 1'b0;
          end
        end
        S_WAIT: begin
          if (stop_req_r) begin
            stop_req_r <= 1'b0;
            state_r <= S_STOP;
            ph_r <= 2'b00;
            cnt_r <= lo_ld;
            sda_oe <= 1'b1;
            sda_out <= 1'b0;
          end
        end
        S_BITLO: begin
          // The ninth bit is the acknowledge slot, so data is released there.
          sda_out <= 1'b0;
          sda_oe <= (bit_r == `ISR_LAST_BIT) ? 1'b0 : !shift_r[7];
          if (cnt_done) begin
            state_r <= S_BITHI;
            scl_oe <= 1'b0;
            cnt_r <= hi_ld;
          end
        end
        S_BITHI: begin
          // Count the high time only once the line is really high.
          if (!scl_s)
            cnt_r <= hi_ld;
          if (scl_s && !sda_oe && !sda_s && bit_r != `ISR_LAST_BIT) begin
            arbloss_r <= 1'b1;
            master_r <= 1'b0;
            state_r <= S_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            bus_interrupt <= 1'b1;
          end else if (scl_s && cnt_done) begin
            scl_oe <= 1'b1;
            scl_out <= 1'b0;
            if (bit_r == `ISR_LAST_BIT) begin
              ack_r <= !sda_s;
              state_r <= S_WAIT;
              bus_interrupt <= 1'b1;
            end else begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
              state_r <= S_BITLO;
              cnt_r <= lo_ld;
            end
          end
        end
        S_STOP: begin
          if (cnt_done) begin
            case (ph_r)
              2'b00: begin
                scl_oe <= 1'b0;
                cnt_r <= hi_ld;
                ph_r <= 2'b01;
              end
              2'b01: begin
                if (scl_s) begin
                  sda_oe <= 1'b0;
                  cnt_r <= hi_ld;
                  ph_r <= 2'b10;
                end
              end
              default: begin
                master_r <= 1'b0;
                state_r <= S_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase

      // Software clears the sticky arbitration flag by writing the status word.
      if (wr && sel(paddr, `ISR_OFS_STAT) && !(state_r == S_BITHI && scl_s && !sda_s))
        arbloss_r <= arbloss_r & pwdata[`ISR_ST_ARBLOSS];
    end
  end
endmodule

/* test/isr_chk.sv */
// Port checks for the start-reservation controller, bound to its top module.
`timescale 1ns/1ps
module isr_chk (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Bus lines and event
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire bus_interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Traffic of other parties
  // ----------------------------------------
  // Set by a start we did not drive, cleared by any stop on the line.
  reg sda_prev_r;
  reg busy_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_prev_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      sda_prev_r <= sda_in;
      if (sda_prev_r && !sda_in && scl_in && !sda_oe)
        busy_r <= 1'b1;
      else if (!sda_prev_r && sda_in && scl_in)
        busy_r <= 1'b0;
    end
  end
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_err_map: assert property (pready |-> pslverr ==
      !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}))
    else $error("error response off the map");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer");
  chk_pull_only: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  chk_irq_pulse: assert property (bus_interrupt |=> !bus_interrupt)
    else $error("interrupt longer than one cycle");
  chk_start_scl_high: assert property ($rose(sda_oe) && !scl_oe |-> scl_in)
    else $error("start made with clock low");
  chk_start_wait: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:600] scl_oe)
    else $error("no wait state after start");
  chk_quiet_busy: assert property (busy_r && !sda_oe && !scl_oe |=> !sda_oe && !scl_oe)
    else $error("line driven while bus occupied");
endmodule
bind isr_start_ctrl isr_chk isr_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .bus_interrupt(bus_interrupt)
);

/* test/isr_peer.sv */
// Peer master on the two-wire bus, framing at the link rate and recording bits.
`timescale 1ns/1ps
module isr_peer (
  // Open-drain lines
  input wire scl,
  input wire sda,
  output logic scl_oe,
  output logic sda_oe,
  // Bits seen since the last start
  output logic [8:0] cap
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    cap = 9'h000;
  end
  // ----------------------------------------
  // Line watch and frames
  // ----------------------------------------
  always @(negedge sda) if (scl) cap = 9'h000;
  always @(posedge scl) cap = {cap[7:0], sda};
  // Start, four pulses with data released, then data low with clock high.
  // The 1 ns offset keeps every change clear of the controller's clock edges.
  task automatic frame_open;
    #1 sda_oe = 1'b1;
    #80 scl_oe = 1'b1;
    #80 sda_oe = 1'b0;
    repeat (4) begin
      #80 scl_oe = 1'b0;
      #80 scl_oe = 1'b1;
    end
    sda_oe = 1'b1;
    #80 scl_oe = 1'b0;
    #80;
  endtask
  // Stop; both lines then stay released, so the clock stands still.
  task automatic frame_close;
    #1 sda_oe = 1'b0;
  endtask
  // Holds data low from outside a frame, as a competing master would.
  task automatic hold_data(input logic v);
    #1 sda_oe = v;
  endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the start-reservation controller with a peer master.
`timescale 1ns/1ps
`include "isr_map.vh"
module tb;
  localparam logic [11:0] C0 = `ISR_OFS_CTRL0;
  localparam logic [11:0] ST = `ISR_OFS_STAT;
  localparam logic [11:0] FL = `ISR_OFS_FLAG;
  localparam logic [31:0] EN = 32'h1 << `ISR_C0_ENABLE;
  localparam logic [31:0] RLS = 32'h1 << `ISR_C0_RELEASE;
  localparam logic [31:0] SPIE = 32'h1 << `ISR_C0_SPIE;
  localparam logic [31:0] STT = 32'h1 << `ISR_C0_START;
  localparam logic [31:0] MST = 32'h1 << `ISR_ST_MASTER;
  localparam logic [31:0] ARB = 32'h1 << `ISR_ST_ARBLOSS;
  localparam logic [31:0] STD = 32'h1 << `ISR_ST_STD;
  localparam logic [31:0] BUSY = 32'h1 << `ISR_FL_BUSY;
  localparam logic [31:0] START_FAILURE_FLAG = 32'h1 << `ISR_FL_START_FAILURE_FLAG;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd_q;
  logic rd_e;
  logic [7:0] wl;
  logic [7:0] wh;
  int n_mismatch = 0;
  int samples_checked = 0;
  wire [31:0] prdata;
  wire pready, pslverr, scl_oe, sda_oe, p_scl_oe, p_sda_oe, bus_interrupt;
  wire [8:0] cap;
  wire scl_w = !(scl_oe || p_scl_oe);
  wire sda_w = !(sda_oe || p_sda_oe);
  always #2 pclk = ~pclk;
  isr_start_ctrl #(.WW(8)) isr_start_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
    .sda_oe(sda_oe), .bus_interrupt(bus_interrupt)
  );
  isr_peer isr_peer_i (.scl(scl_w), .sda(sda_w), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .cap(cap));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Lines are ideal here, so a small margin stands in for the fall-time term.
  function automatic int settle(input logic [7:0] l, input logic [7:0] h);
    return l + h + 4 + 8;
  endfunction
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_mismatch++;
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd_q & m, e);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bus_interrupt !== 1'b1 && n < 3000);
    check("bus_interrupt", {31'h0, bus_interrupt}, 32'h1);
  endtask
  task automatic stop_bus;
    wr(C0, EN | SPIE | (32'h1 << `ISR_C0_STOP));
    wait_irq;
  endtask
  task automatic send_byte(input logic [7:0] a);
    wr(`ISR_OFS_SHIFT, {24'h0, a});
    wait_irq;
    check("peer_bits", {23'h0, cap}, {23'h0, a, 1'b1});
    rd_chk(ST, 32'h1 << `ISR_ST_ACK, 32'h0, "ack_bit");
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    void'($urandom(59));
    wl = 8'h02 + 8'($urandom % 6);
    wh = 8'h02 + 8'($urandom % 6);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(C0, '1, 32'h0, "ctrl0_reset");
    rd_chk(ST, '1, 32'h0, "status_reset");
    rd_chk(FL, '1, 32'h0, "flag_reset");
    rd_chk(`ISR_OFS_WIDTH, '1, {16'h0, `ISR_WIDTH_RST, `ISR_WIDTH_RST}, "width_reset");
    apb(1'b0, 12'h014, 32'h0);
    check("unmapped", {rd_q[30:0], rd_e}, 32'h1);
    wr(`ISR_OFS_WIDTH, {16'h0, wh, wl});
    wr(C0, EN | SPIE);
    rd_chk(FL, BUSY, BUSY, "busy_forced");
    stop_bus;
    rd_chk(FL, BUSY, 32'h0, "busy_after_stop");
    wr(C0, EN | SPIE | STT);
    repeat (settle(wl, wh)) @(posedge pclk);
    rd_chk(ST, MST, MST, "master_direct");
    check("wait_lines", {30'h0, scl_w, sda_w}, 32'h0);
    send_byte(8'($urandom));
    isr_peer_i.hold_data(1'b1);
    wr(`ISR_OFS_SHIFT, 32'h0000_0080);
    wait_irq;
    rd_chk(ST, MST | ARB, ARB, "arb_lost");
    check("arb_release", {30'h0, scl_oe, sda_oe}, 32'h0);
    wr(ST, 32'h0);
    rd_chk(ST, ARB, 32'h0, "arb_cleared");
    isr_peer_i.hold_data(1'b0);
    wait_irq;
    stop_bus;
    isr_peer_i.frame_open;
    wr(C0, EN | SPIE | STT);
    repeat (settle(wl, wh)) @(posedge pclk);
    rd_chk(ST, MST, 32'h0, "reserved_pending");
    wr(`ISR_OFS_SHIFT, 32'h0000_00C3);
    rd_chk(`ISR_OFS_SHIFT, 32'hFF, 32'h80, "shift_kept");
    isr_peer_i.frame_close;
    wait_irq;
    repeat (settle(wl, wh)) @(posedge pclk);
    rd_chk(ST, MST, MST, "reserved_start");
    check("stale_byte", {23'h0, cap}, 32'h0);
    send_byte(8'h00);
    stop_bus;
    wr(FL, 32'h1 << `ISR_FL_RSVDIS);
    isr_peer_i.frame_open;
    wr(C0, EN | SPIE | STT);
    repeat (3) @(posedge pclk);
    rd_chk(FL, START_FAILURE_FLAG, START_FAILURE_FLAG, "start_refused");
    rd_chk(ST, MST, 32'h0, "refused_master");
    isr_peer_i.frame_close;
    wait_irq;
    wr(C0, 32'h0);
    wr(FL, 32'h1 << `ISR_FL_START_WITHOUT_STOP_ENABLE);
    wr(C0, EN);
    rd_chk(FL, BUSY, 32'h0, "busy_cleared");
    wr(C0, 32'h0);
    isr_peer_i.frame_open;
    wr(C0, EN);
    rd_chk(ST, STD, STD, "start_on_enable");
    wr(C0, EN | RLS);
    rd_chk(C0, RLS, 32'h0, "release_self_clear");
    isr_peer_i.frame_close;
    repeat (20) @(posedge pclk);
    complete_run;
  end
endmodule
